// ---- rtl/boot_mode_loader.sv ----
// Boot source selection and loader front end
// Assumes one 200 MHz clock, synchronous active-low reset, synchronous pins
module boot_mode_loader
  import boot_mode_loader_pkg::*;
#(
  parameter int WORD_W     = 16,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              soft_reset_in,
  input  wire logic [3:0]        boot_select_pins_in,
  input  wire logic              alt_wait_enable_fuse_in,
  input  wire logic              pf_ready_fuse_in,
  input  wire logic              wait_pull_sense_in,
  input  wire logic              loader_ready_in,
  input  wire logic              baud_detected_in,
  input  wire logic [7:0]        divisor_latch_low_in,
  input  wire logic [7:0]        divisor_latch_high_in,
  input  wire logic              clear_to_send_in,
  input  wire logic              tx_ready_in,
  input  wire logic              sig_valid_in,
  input  wire logic [7:0]        sig_byte_in,
  input  wire logic              src_valid_in,
  output logic                   src_ready_out,
  input  wire logic [WORD_W-1:0] src_data_in,
  output logic                   word_valid_out,
  input  wire logic              word_ready_in,
  output logic      [WORD_W-1:0] word_data_out,
  output logic                   default_wait_pin_out,
  output logic                   default_wait_pin_oe_n_out,
  output logic                   alternate_wait_pin_out,
  output logic                   alternate_wait_pin_oe_n_out,
  output logic                   fifo_word_request_n_out,
  output logic                   memory_select_gpio_n_out,
  output logic                   request_to_send_out,
  output logic                   nand_select_port_en_out,
  output logic                   nand_ready_port_en_out,
  output logic                   tx_valid_out,
  output logic      [7:0]        tx_byte_out,
  output logic                   boot_active_out,
  output logic                   boot_idle_out,
  output logic      [31:0]       load_addr_out,
  output logic      [3:0]        boot_mode_out,
  output pf_timing_s             pf_timing_out,
  output periph_cfg_s            periph_cfg_out,
  output nand_geom_s             nand_geom_out,
  output logic      [2:0]        nand_addr_cycles_out
);
`include "boot_mode_loader_consts.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic decode_s decode_mode(input logic [3:0] code);
    decode_s d;
    d = '{mode: code, cat: SRC_NONE, start_addr: 32'h0000_0000, wait_used: 1'b0};
    unique case (code)
      `BSEL_PFLASH:    begin d.cat = SRC_MASTER; d.start_addr = `PFLASH_START; end
      `BSEL_AFIFO:     begin d.cat = SRC_MASTER; d.start_addr = `AFIFO_START;  end
      `BSEL_SPI_MEM:   d.cat = SRC_MASTER;
      `BSEL_TW_MEM:    d.cat = SRC_MASTER;
      `BSEL_DDR:       begin d.cat = SRC_MASTER; d.start_addr = `DDR_START;    end
      `BSEL_OTP:       d.cat = SRC_MASTER;
      `BSEL_NAND:      begin d.cat = SRC_MASTER; d.start_addr = `NAND_START;   end
      `BSEL_SPI_HOST:  begin d.cat = SRC_SLAVE; d.wait_used = 1'b1; end
      `BSEL_TW_HOST:   begin d.cat = SRC_SLAVE; d.wait_used = 1'b1; end
      `BSEL_UART_HOST: begin d.cat = SRC_SLAVE; d.wait_used = 1'b1; end
      `BSEL_HDMA16:    begin d.cat = SRC_SLAVE; d.wait_used = 1'b1; end
      `BSEL_HDMA8:     begin d.cat = SRC_SLAVE; d.wait_used = 1'b1; end
      default:         d.cat = SRC_NONE; // Idle and reserved codes
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Data path buffer
  logic             buf_in_ready;
  logic             buf_in_valid;
  logic             loading;
  logic             ack_fire;
  logic [7:0]       ack_byte;
  state_s           s_q;
  state_s           s_d;

  assign loading      = (s_q.phase == ST_LOAD);
  assign buf_in_valid = src_valid_in && loading;
  assign src_ready_out = buf_in_ready && loading;

  boot_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_buf (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (buf_in_valid),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (src_data_in),
    .out_valid_out (word_valid_out),
    .out_ready_in  (word_ready_in),
    .out_data_out  (word_data_out)
  );

  always_comb
  begin
    unique case (s_q.ack_idx)
      2'd0: ack_byte = `UART_ACK0;
      2'd1: ack_byte = divisor_latch_low_in;
      2'd2: ack_byte = divisor_latch_high_in;
      2'd3: ack_byte = `UART_ACK3;
    endcase
  end
  assign ack_fire = (s_q.phase == ST_ACK) && tx_ready_in;

  ////////////////////////////////////////////////////////////////////////////
  // State update
  always_comb
  begin
    s_d = s_q;
    if (s_q.req_cnt != 4'h0)
      s_d.req_cnt = s_q.req_cnt - 4'h1;
    unique case (s_q.phase)
      ST_RESET:
      begin
        s_d.dec       = decode_mode(boot_select_pins_in);
        s_d.wait_high = wait_pull_sense_in;
        s_d.phase     = (s_d.dec.cat == SRC_NONE)
                        ? ST_IDLE : ST_SETUP;
      end
      ST_IDLE: s_d.phase = ST_IDLE;
      ST_SETUP:
      begin
        s_d.pf   = '{setup: `PF_SETUP, access: `PF_ACCESS, hold: `PF_HOLD,
                     ready_en: pf_ready_fuse_in};
        s_d.cfg  = '{spi_div: `SPI_RATE_DIV, tw_prescale: `TW_PRESCALE,
                     tw_two_wire_clock_divider: `TW_TWO_WIRE_CLOCK_DIVIDER, nand_ctl: `NAND_CTL_VAL,
                     tw_slave: (s_q.dec.mode == `BSEL_TW_HOST) ? {1'b0, `TW_HOST_ADDR}
                               : `TW_MEM_ADDR,
                     tw_int_addr: `TW_INT_ADDR};
        s_d.addr = s_q.dec.start_addr;
        if (s_q.dec.mode == `BSEL_UART_HOST)
        begin
          if (baud_detected_in)
          begin
            s_d.phase   = ST_ACK;
            s_d.ack_idx = 2'd0;
          end
        end
        else
          s_d.phase = ST_LOAD;
      end
      ST_ACK:
      begin
        if (ack_fire)
        begin
          s_d.ack_idx = s_q.ack_idx + 2'd1;
          if (s_q.ack_idx == 2'd3)
            s_d.phase = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        if (sig_valid_in && s_q.dec.mode == `BSEL_NAND)
        begin
          if (s_q.sig_cnt != `NAND_SIG_BYTES)
            s_d.sig_cnt = s_q.sig_cnt + 3'h1;
          if (s_q.sig_cnt == `NAND_SIG_BYTES - 3'h1)
            s_d.geom = '{page_code: sig_byte_in, page_sz: sig_byte_in[1:0],
                         spare16: sig_byte_in[2], block_sz: sig_byte_in[5:4],
                         bus16: sig_byte_in[6]};
        end
        if (buf_in_valid && buf_in_ready)
        begin
          s_d.addr = s_q.addr + 32'h2;
          if (s_q.dec.mode == `BSEL_AFIFO)
            s_d.req_cnt = `FIFO_REQ_LOW;
        end
        if (loader_ready_in && !word_valid_out && !src_valid_in)
          s_d.boot_done = 1'b1;
      end
      default: s_d.phase = ST_RESET;
    endcase
    if (soft_reset_in)
    begin
      s_d.phase   = ST_RESET;
      s_d.req_cnt = 4'h0;
      s_d.sig_cnt = 3'h0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      s_q <= '{phase: ST_RESET, dec: '{mode: 4'h0, cat: SRC_NONE, start_addr: 32'h0,
               wait_used: 1'b0}, pf: '0, cfg: '0, geom: '0, wait_high: 1'b1,
               addr: 32'h0, ack_idx: 2'd0, sig_cnt: 3'h0, req_cnt: 4'h0,
               boot_done: 1'b0};
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  logic wait_level;
  logic wait_drive;
  logic is_nand;
  // Ready asserts to the inactive level of the sensed pull
  assign wait_level = (loading && buf_in_ready) ? ~s_q.wait_high : s_q.wait_high;
  assign is_nand    = (s_q.dec.mode == `BSEL_NAND);
  assign wait_drive = s_q.dec.wait_used && !is_nand &&
                      (s_q.phase != ST_RESET) && (s_q.phase != ST_IDLE);

  assign default_wait_pin_out        = wait_level;
  assign default_wait_pin_oe_n_out   = !(wait_drive && !alt_wait_enable_fuse_in);
  assign alternate_wait_pin_out      = wait_level;
  assign alternate_wait_pin_oe_n_out = !(wait_drive && alt_wait_enable_fuse_in);
  assign fifo_word_request_n_out     = (s_q.req_cnt == 4'h0);
  assign memory_select_gpio_n_out    = !(loading && s_q.dec.mode == `BSEL_SPI_MEM);
  // Clear-to-send is never looked at during boot
  assign request_to_send_out = (s_q.dec.mode == `BSEL_UART_HOST) && loading &&
                               buf_in_ready;
  assign nand_select_port_en_out = is_nand && loading;
  assign nand_ready_port_en_out  = is_nand && loading;
  assign tx_valid_out   = (s_q.phase == ST_ACK);
  assign tx_byte_out    = ack_byte;
  assign boot_active_out = loading || (s_q.phase == ST_ACK) || (s_q.phase == ST_SETUP);
  assign boot_idle_out  = (s_q.phase == ST_IDLE);
  assign load_addr_out  = s_q.addr;
  assign boot_mode_out  = s_q.dec.mode;
  assign pf_timing_out  = s_q.pf;
  assign periph_cfg_out = s_q.cfg;
  assign nand_geom_out  = s_q.geom;
  assign nand_addr_cycles_out = (s_q.geom.page_code != 8'h00) ? `NAND_LP_ACYC
                                : `NAND_SP_ACYC;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_IDLE_NO_LOAD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.phase == ST_IDLE |-> !src_ready_out && memory_select_gpio_n_out)
    else $error("idle state accepted data");
  AST_RESERVED_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rst_n_in && s_q.phase == ST_RESET && !soft_reset_in && boot_select_pins_in inside
    {4'h8, 4'h9, 4'hc} |=> s_q.phase == ST_IDLE)
    else $error("reserved code did not idle");
  AST_SAMPLE_MODE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rst_n_in && s_q.phase == ST_RESET && !soft_reset_in
    |=> boot_mode_out == $past(boot_select_pins_in))
    else $error("select pins not sampled");
  AST_NAND_FLOAT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    is_nand |-> default_wait_pin_oe_n_out && alternate_wait_pin_oe_n_out)
    else $error("wait pin driven in nand boot");
  AST_ALT_WAIT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    alt_wait_enable_fuse_in |-> default_wait_pin_oe_n_out)
    else $error("default wait pin driven with fuse set");
  AST_FIFO_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in || soft_reset_in)
    loading && s_q.dec.mode == `BSEL_AFIFO && buf_in_valid && buf_in_ready
    |=> !fifo_word_request_n_out [*2] ##1 fifo_word_request_n_out || buf_in_valid)
    else $error("fifo request pulse wrong");
  AST_ACK_FIRST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.phase == ST_ACK && s_q.ack_idx == 2'd0 |-> tx_byte_out == 8'hbf)
    else $error("ack byte zero wrong");
  AST_TIMING: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    loading |-> pf_timing_out.setup == 4'h4 && pf_timing_out.access == 4'hf
    && pf_timing_out.hold == 4'h3 && periph_cfg_out.spi_div == 8'h85
    && periph_cfg_out.tw_two_wire_clock_divider == 16'h0811)
    else $error("default timing wrong");
  AST_RTS_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !buf_in_ready |-> !request_to_send_out)
    else $error("request to send not held off");
  AST_NAND_ROUTE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    loading && is_nand |-> nand_select_port_en_out && nand_ready_port_en_out
    && periph_cfg_out.nand_ctl == 16'h0033)
    else $error("nand routing or control value wrong");
endmodule

// ---- rtl/boot_mode_loader_consts.svh ----
// Constants of the boot mode loader: codes, addresses, defaults, timings
// Assumes inclusion by the loader module only
`ifndef BOOT_MODE_LOADER_CONSTS_SVH
`define BOOT_MODE_LOADER_CONSTS_SVH
`define BSEL_IDLE      4'h0
`define BSEL_PFLASH    4'h1
`define BSEL_AFIFO     4'h2
`define BSEL_SPI_MEM   4'h3
`define BSEL_SPI_HOST  4'h4
`define BSEL_TW_MEM    4'h5
`define BSEL_TW_HOST   4'h6
`define BSEL_UART_HOST 4'h7
`define BSEL_DDR       4'ha
`define BSEL_OTP       4'hb
`define BSEL_NAND      4'hd
`define BSEL_HDMA16    4'he
`define BSEL_HDMA8     4'hf
`define PFLASH_START   32'h2000_0000
`define AFIFO_START    32'h2030_0000
`define DDR_START      32'h0000_0010
`define NAND_START     32'h0000_0000
`define SPI_RATE_DIV   8'h85
`define SPI_ADDR_BYTE  8'h00
`define TW_MEM_ADDR    8'ha0
`define TW_HOST_ADDR   7'h5f
`define TW_INT_ADDR    16'h0000
`define TW_PRESCALE    8'h0a
`define TW_TWO_WIRE_CLOCK_DIVIDER      16'h0811
`define PF_SETUP       4'h4
`define PF_ACCESS      4'hf
`define PF_HOLD        4'h3
`define NAND_CTL_VAL   16'h0033
`define NAND_SP_ACYC   3'h4
`define NAND_LP_ACYC   3'h5
`define NAND_SIG_BYTES 3'h4
`define UART_AUTOBAUD  8'h40
`define UART_ACK0      8'hbf
`define UART_ACK3      8'h00
`define FIFO_REQ_LOW   4'h2
`endif

// ---- rtl/boot_mode_loader_pkg.sv ----
// Types of the boot mode loader
// Assumes the constants header is available for inclusion
package boot_mode_loader_pkg;
  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_IDLE  = 5'b00010,
    ST_SETUP = 5'b00100,
    ST_LOAD  = 5'b01000,
    ST_ACK   = 5'b10000
  } phase_e;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_MASTER = 2'h1,
    SRC_SLAVE = 2'h2
  } category_e;

  typedef struct packed {
    logic [3:0]  mode;
    category_e   cat;
    logic [31:0] start_addr;
    logic        wait_used;
  } decode_s;

  typedef struct packed {
    logic [3:0]  setup;
    logic [3:0]  access;
    logic [3:0]  hold;
    logic        ready_en;
  } pf_timing_s;

  typedef struct packed {
    logic [7:0]  spi_div;
    logic [7:0]  tw_prescale;
    logic [15:0] tw_two_wire_clock_divider;
    logic [15:0] nand_ctl;
    logic [7:0]  tw_slave;
    logic [15:0] tw_int_addr;
  } periph_cfg_s;

  typedef struct packed {
    logic [7:0] page_code;
    logic [1:0] page_sz;
    logic       spare16;
    logic [1:0] block_sz;
    logic       bus16;
  } nand_geom_s;

  typedef struct packed {
    phase_e      phase;
    decode_s     dec;
    pf_timing_s  pf;
    periph_cfg_s cfg;
    nand_geom_s  geom;
    logic        wait_high;
    logic [31:0] addr;
    logic [1:0]  ack_idx;
    logic [2:0]  sig_cnt;
    logic [3:0]  req_cnt;
    logic        boot_done;
  } state_s;
endpackage

// ---- rtl/boot_fifo.sv ----
// Synchronous word FIFO with valid/ready on both sides
// Assumes one clock and synchronous active-low reset
module boot_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_q[rd_q];

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data_in;
        wr_q        <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- tb/boot_src_model.sv ----
// Partner: boot memory handing 16-bit words to the loader
// Assumes one clock; a word is held until the loader's ready is seen high
module boot_src_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        go_in,
  input  wire logic        slow_in,
  input  wire logic        ready_in,
  output logic             valid_out,
  output logic      [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seq_q;
  logic [7:0] nxt;
  int         seed = 62915;
  assign nxt = seq_q + {7'h00, valid_out};
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      valid_out <= 1'b0;
      seq_q     <= 8'h00;
      data_out  <= 16'hffff;
    end
    else if (!valid_out || ready_in)
    begin
      seq_q     <= nxt;
      valid_out <= go_in && (!slow_in || ($random(seed) % 3 == 0));
      if (go_in)
        data_out <= {nxt, ~nxt};
      else
        data_out <= ~data_out;
    end
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the boot mode loader
// Assumes the design files and the partner source model are compiled first
module tb import boot_mode_loader_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, rst_n_in, soft_reset_in, alt_wait_enable_fuse_in, pf_ready_fuse_in;
  logic        wait_pull_sense_in, loader_ready_in, baud_detected_in, clear_to_send_in;
  logic        tx_ready_in, sig_valid_in, src_valid_in, src_ready_out, word_valid_out;
  logic        word_ready_in, default_wait_pin_out, default_wait_pin_oe_n_out;
  logic        alternate_wait_pin_out, alternate_wait_pin_oe_n_out, fifo_word_request_n_out;
  logic        memory_select_gpio_n_out, request_to_send_out, nand_select_port_en_out;
  logic        nand_ready_port_en_out, tx_valid_out, boot_active_out, boot_idle_out;
  logic        go, slow, sink_on;
  logic [3:0]  boot_select_pins_in, boot_mode_out;
  logic [7:0]  divisor_latch_low_in, divisor_latch_high_in, sig_byte_in, tx_byte_out, sb;
  logic [15:0] src_data_in, word_data_out;
  logic [31:0] load_addr_out;
  logic [2:0]  nand_addr_cycles_out;
  pf_timing_s  pf_timing_out;
  periph_cfg_s periph_cfg_out;
  nand_geom_s  nand_geom_out;
  int          num_errors, n_compared, seed, n_acc, n_low, n_out, k;
  boot_mode_loader #(.WORD_W(16), .FIFO_DEPTH(8)) uut (.clk_in, .rst_n_in, .soft_reset_in,
    .boot_select_pins_in, .alt_wait_enable_fuse_in, .pf_ready_fuse_in, .wait_pull_sense_in,
    .loader_ready_in, .baud_detected_in, .divisor_latch_low_in, .divisor_latch_high_in,
    .clear_to_send_in, .tx_ready_in, .sig_valid_in, .sig_byte_in, .src_valid_in,
    .src_ready_out, .src_data_in, .word_valid_out, .word_ready_in, .word_data_out,
    .default_wait_pin_out, .default_wait_pin_oe_n_out, .alternate_wait_pin_out,
    .alternate_wait_pin_oe_n_out, .fifo_word_request_n_out, .memory_select_gpio_n_out,
    .request_to_send_out, .nand_select_port_en_out, .nand_ready_port_en_out, .tx_valid_out,
    .tx_byte_out, .boot_active_out, .boot_idle_out, .load_addr_out, .boot_mode_out,
    .pf_timing_out, .periph_cfg_out, .nand_geom_out, .nand_addr_cycles_out);
  boot_src_model src (.clk_in, .rst_n_in, .go_in(go), .slow_in(slow),
    .ready_in(src_ready_out), .valid_out(src_valid_in), .data_out(src_data_in));
  always #2.5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Reset with a new select code and random fuse and pull levels
  task automatic boot(input logic [3:0] c);
    @(posedge clk_in);
    rst_n_in                <= 1'b0;
    boot_select_pins_in     <= c;
    alt_wait_enable_fuse_in <= $random(seed);
    pf_ready_fuse_in        <= $random(seed);
    wait_pull_sense_in      <= $random(seed);
    go                      <= 1'b0;
    sink_on                 <= 1'b0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    n_acc = 0;
    n_low = 0;
    n_out = 0;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic sweep(input logic [3:0] c);
    logic idle;
    logic alt;
    idle = c inside {4'h0, 4'h8, 4'h9, 4'hc};
    boot(c);
    alt = alt_wait_enable_fuse_in;
    check("idle", boot_idle_out, idle);
    check("active", boot_active_out, !idle);
    if (!idle)
      check("mode", boot_mode_out, c);
    check("mem_sel_n", memory_select_gpio_n_out, c != 4'h3);
    check("nand_en", {nand_select_port_en_out, nand_ready_port_en_out}, {2{c == 4'hd}});
    case (c)
      4'h1: check("pf", {load_addr_out, pf_timing_out},
                  {32'h2000_0000, 4'h4, 4'hf, 4'h3, pf_ready_fuse_in});
      4'h2: check("fifo_addr", load_addr_out, 32'h2030_0000);
      4'h3: check("spi_div", periph_cfg_out.spi_div, 8'h85);
      4'h5: check("tw", {periph_cfg_out.tw_slave, periph_cfg_out.tw_int_addr,
                  periph_cfg_out.tw_prescale, periph_cfg_out.tw_two_wire_clock_divider},
                  {8'ha0, 16'h0000, 8'h0a, 16'h0811});
      4'ha: check("ddr_addr", load_addr_out, 32'h0000_0010);
      4'hd: check("nand", {load_addr_out, periph_cfg_out.nand_ctl, default_wait_pin_oe_n_out,
                  alternate_wait_pin_oe_n_out, nand_addr_cycles_out},
                  {32'h0, 16'h0033, 2'b11, 3'h4});
      4'h4, 4'h6:
      begin
        check("wait_oe", {default_wait_pin_oe_n_out, alternate_wait_pin_oe_n_out},
              {alt, !alt});
        // Empty buffer in the load phase means ready for data
        check("wait_lvl", alt ? alternate_wait_pin_out : default_wait_pin_out,
              !wait_pull_sense_in);
        if (c == 4'h6)
          check("tw_host", periph_cfg_out.tw_slave, 8'h5f);
      end
      default: ;
    endcase
  endtask
  task automatic fill();
    go <= 1'b1;
    for (int i = 0; i < 60 && !(n_acc > 0 && !src_ready_out); i++)
      @(negedge clk_in);
    go <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in)
  begin
    if (src_valid_in && src_ready_out)
      n_acc++;
    if (fifo_word_request_n_out === 1'b0)
      n_low++;
    if (word_valid_out && word_ready_in)
    begin
      check("word", word_data_out, {n_out[7:0], ~n_out[7:0]});
      n_out++;
    end
    word_ready_in    <= sink_on && ($random(seed) & 1);
    clear_to_send_in <= $random(seed);
  end
  initial
  begin
    #(20000 * 5);
    num_errors++;
    results();
  end
  initial
  begin
    {clk_in, rst_n_in, soft_reset_in, loader_ready_in, baud_detected_in, tx_ready_in} = '0;
    {sig_valid_in, sig_byte_in, divisor_latch_low_in, divisor_latch_high_in} = '0;
    {go, slow, sink_on, word_ready_in, clear_to_send_in, boot_select_pins_in} = '0;
    {alt_wait_enable_fuse_in, pf_ready_fuse_in, wait_pull_sense_in} = '0;
    {num_errors, n_compared, n_acc, n_low, n_out} = '0;
    seed = 62915;
    repeat (12) @(posedge clk_in);
    for (int i = 0; i < 48; i++)
      sweep(i[3:0]);
    // Fill the buffer until it refuses, then drain with stalls
    boot(4'h1);
    slow <= 1'b1;
    fill();
    check("full", n_acc, 8);
    check("addr_step", load_addr_out, 32'h2000_0010);
    sink_on <= 1'b1;
    repeat (120) @(negedge clk_in);
    check("drained", {n_out, word_valid_out}, {n_acc, 1'b0});
    // One word at a time, two low request cycles each
    boot(4'h2);
    sink_on <= 1'b1;
    slow    <= 1'b0;
    for (k = 1; k < 4; k++)
    begin
      @(posedge clk_in);
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      repeat (12) @(negedge clk_in);
      check("req_low", {n_low, load_addr_out}, {2 * k, 32'h2030_0000 + 2 * k});
    end
    // Autobaud reply, then flow control
    boot(4'h7);
    divisor_latch_low_in  <= $random(seed);
    divisor_latch_high_in <= $random(seed);
    baud_detected_in      <= 1'b1;
    @(posedge clk_in);
    baud_detected_in <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      for (int i = 0; i < 20 && tx_valid_out !== 1'b1; i++)
        @(negedge clk_in);
      check("ack", tx_byte_out, k == 0 ? 8'hbf : k == 1 ? divisor_latch_low_in
            : k == 2 ? divisor_latch_high_in : 8'h00);
      @(posedge clk_in);
      tx_ready_in <= 1'b1;
      @(posedge clk_in);
      tx_ready_in <= 1'b0;
      @(negedge clk_in);
    end
    repeat (4) @(negedge clk_in);
    check("rts_room", request_to_send_out, 1'b1);
    fill();
    check("rts_full", {src_ready_out, request_to_send_out}, 2'b00);
    // Signature byte four configures large-page geometry
    boot(4'hd);
    sb = $random(seed) | 8'h01;
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk_in);
      sig_valid_in <= 1'b1;
      sig_byte_in  <= k == 3 ? sb : $random(seed);
    end
    @(posedge clk_in);
    sig_valid_in <= 1'b0;
    repeat (3) @(negedge clk_in);
    check("geom", {nand_geom_out.page_sz, nand_geom_out.spare16, nand_geom_out.block_sz,
          nand_geom_out.bus16, nand_addr_cycles_out}, {sb[1:0], sb[2], sb[5:4], sb[6], 3'h5});
    // Pins are only sampled at a reset, soft reset included
    boot(4'h1);
    boot_select_pins_in <= 4'ha;
    repeat (5) @(negedge clk_in);
    check("no_resample", boot_mode_out, 4'h1);
    @(posedge clk_in);
    boot_select_pins_in <= 4'h5;
    soft_reset_in       <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    repeat (8) @(negedge clk_in);
    check("soft_reset", boot_mode_out, 4'h5);
    results();
  end
endmodule
